// ===== hw/rxg_pkg.sv
// Package with register map, field layout, reset values and shared types of the receive guard block.
package rxg_pkg;
    localparam logic [7:0] SEL_OFFSET       = 8'h17;
    localparam logic [7:0] THR_OFFSET       = 8'h18;
    localparam logic [7:0] SEL_RESET        = 8'h84;
    localparam logic [7:0] THR_RESET        = 8'h84;
    localparam int         UART_SEL_MSB     = 7;
    localparam int         UART_SEL_LSB     = 6;
    localparam int         GUARD_MSB        = 5;
    localparam int         GUARD_LSB        = 0;
    localparam int         MIN_MSB          = 7;
    localparam int         MIN_LSB          = 4;
    localparam int         RSVD_BIT         = 3;
    localparam int         COLL_MSB         = 2;
    localparam int         COLL_LSB         = 0;
    localparam int         AMP_W            = 8;
    localparam int         COLL_SHIFT       = 3;
    localparam logic [7:0] THR_WR_MASK      = 8'hF7;

    typedef enum logic [1:0] {
        RXG_UART_LOW     = 2'b00,
        RXG_UART_ENV_PIN = 2'b01,
        RXG_UART_ANALOG  = 2'b10,
        RXG_UART_MOD_PIN = 2'b11
    } rxg_uart_sel_t;

    typedef enum logic [1:0] {
        RXG_ST_IDLE  = 2'b00,
        RXG_ST_ARMED = 2'b01,
        RXG_ST_GUARD = 2'b10,
        RXG_ST_RECV  = 2'b11
    } rxg_state_t;

    typedef struct packed {
        logic [1:0] uart_sel;
        logic [5:0] guard;
        logic [3:0] min_level;
        logic [2:0] coll_level;
    } rxg_cfg_t;

    typedef struct packed {
        logic             valid;
        logic [AMP_W-1:0] amp_first;
        logic [AMP_W-1:0] amp_second;
    } rxg_halfbits_t;
endpackage

// ===== hw/rxg_regs.sv
// Register file holding the receiver select and threshold registers.
module rxg_regs (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // Register port
    input  wire logic [7:0]       addr_i,
    input  wire logic [7:0]       wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic      [7:0]       rdata_o,
    // Raw register contents
    output logic      [7:0]       sel_o,
    output logic      [7:0]       thr_o
);
    logic [7:0] sel_reg;
    logic [7:0] sel_next;
    logic [7:0] thr_reg;
    logic [7:0] thr_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    always_comb begin
        sel_next   = sel_reg;
        thr_next   = thr_reg;
        rdata_next = 8'h00;
        if (wr_i && addr_i == rxg_pkg::SEL_OFFSET) begin
            sel_next = wdata_i;
        end else if (wr_i && addr_i == rxg_pkg::THR_OFFSET) begin
            thr_next = wdata_i & rxg_pkg::THR_WR_MASK;
        end
        if (rd_i && addr_i == rxg_pkg::SEL_OFFSET) begin
            rdata_next = sel_reg;
        end else if (rd_i && addr_i == rxg_pkg::THR_OFFSET) begin
            rdata_next = thr_reg;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_reg   <= rxg_pkg::SEL_RESET;
            thr_reg   <= rxg_pkg::THR_RESET;
            rdata_reg <= 8'h00;
        end else begin
            sel_reg   <= sel_next;
            thr_reg   <= thr_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign sel_o   = sel_reg;
    assign thr_o   = thr_reg;
endmodule

// ===== hw/rxg_top.sv
// Receive input select, frame guard delay and decoder threshold control.
// Summary of operation
// - UART input code: 00 low, 01 envelope pin, 10 analog modulation, 11 pin modulation.
// - After transmit, receiver waits guard-delay bit clocks, ignoring the receive input.
// - Receive-only command skips the guard delay; all other commands apply it.
// - Passive mode: guard count starts at the last transmitted modulation pulse.
// - Active mode: guard count starts as soon as the external field switches on.
// - Decoder ignores bits whose stronger half-bit strength is below the minimum level field.
// - Collision flagged only when weaker half-bit reaches threshold relative to stronger.
// - Threshold bit 3 is reserved, has no function and reads zero.
// - Receiver select register at 17h resets to 84h.
// - Threshold register at 18h resets to 84h.
//
// Implementation choice: the plain strobed port.
module rxg_top (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     sys_rst_i,
    // Register port
    input  wire logic [7:0]               addr_i,
    input  wire logic [7:0]               wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output logic      [7:0]               rdata_o,
    // Sequencer events
    input  wire logic                     cmd_start_i,
    input  wire logic                     cmd_recv_only_i,
    input  wire logic                     active_mode_i,
    input  wire logic                     last_mod_pulse_i,
    input  wire logic                     ext_field_on_i,
    input  wire logic                     bit_clk_i,
    input  wire logic                     frame_end_i,
    // Receive inputs
    input  wire logic                     envelope_input_pin_i,
    input  wire logic                     pin_mod_i,
    input  wire logic                     analog_mod_i,
    input  wire rxg_pkg::rxg_halfbits_t   halfbits_i,
    // Receive outputs
    output logic                          uart_in_o,
    output logic                          rx_enable_o,
    output logic                          bit_valid_o,
    output logic                          bit_value_o,
    output logic                          bit_coll_o,
    output logic                          guard_busy_o
);
    logic [7:0]          sel_raw;
    logic [7:0]          thr_raw;
    rxg_pkg::rxg_cfg_t   live_cfg;
    rxg_pkg::rxg_cfg_t   cfg_reg;
    rxg_pkg::rxg_cfg_t   cfg_next;
    rxg_pkg::rxg_state_t state_reg;
    rxg_pkg::rxg_state_t state_next;
    logic [5:0]          cnt_reg;
    logic [5:0]          cnt_next;
    logic                uart_reg;
    logic                uart_next;
    logic                valid_reg;
    logic                valid_next;
    logic                value_reg;
    logic                value_next;
    logic                coll_reg;
    logic                coll_next;
    logic [rxg_pkg::AMP_W-1:0] amp_hi;
    logic [rxg_pkg::AMP_W-1:0] amp_lo;

    rxg_regs u_regs (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .addr_i    (addr_i),
        .wdata_i   (wdata_i),
        .wr_i      (wr_i),
        .rd_i      (rd_i),
        .rdata_o   (rdata_o),
        .sel_o     (sel_raw),
        .thr_o     (thr_raw)
    );

    // Strength of a half-bit on the four-bit level scale used by the minimum threshold.
    function automatic logic [3:0] level_of(input logic [rxg_pkg::AMP_W-1:0] amp);
        level_of = amp[rxg_pkg::AMP_W-1 -: 4];
    endfunction

    always_comb begin
        live_cfg.uart_sel   = sel_raw[rxg_pkg::UART_SEL_MSB:rxg_pkg::UART_SEL_LSB];
        live_cfg.guard      = sel_raw[rxg_pkg::GUARD_MSB:rxg_pkg::GUARD_LSB];
        live_cfg.min_level  = thr_raw[rxg_pkg::MIN_MSB:rxg_pkg::MIN_LSB];
        live_cfg.coll_level = thr_raw[rxg_pkg::COLL_MSB:rxg_pkg::COLL_LSB];
    end

    // Guard sequencer; the configuration is latched once per command so a frame never sees a change.
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        cfg_next   = cfg_reg;
        if (cmd_start_i) begin
            cfg_next = live_cfg;
            if (cmd_recv_only_i) begin
                state_next = rxg_pkg::RXG_ST_RECV;
            end else begin
                state_next = rxg_pkg::RXG_ST_ARMED;
            end
        end else begin
            case (state_reg)
                rxg_pkg::RXG_ST_IDLE: begin
                end
                rxg_pkg::RXG_ST_ARMED: begin
                    if ((active_mode_i && ext_field_on_i) || (!active_mode_i && last_mod_pulse_i)) begin
                        cnt_next   = cfg_reg.guard;
                        state_next = (cfg_reg.guard == 6'h00) ? rxg_pkg::RXG_ST_RECV : rxg_pkg::RXG_ST_GUARD;
                    end
                end
                rxg_pkg::RXG_ST_GUARD: begin
                    if (bit_clk_i) begin
                        cnt_next = cnt_reg - 6'h01;
                        if (cnt_reg == 6'h01) begin
                            state_next = rxg_pkg::RXG_ST_RECV;
                        end
                    end
                end
                rxg_pkg::RXG_ST_RECV: begin
                    if (frame_end_i) begin
                        state_next = rxg_pkg::RXG_ST_IDLE;
                    end
                end
                default: state_next = rxg_pkg::RXG_ST_IDLE;
            endcase
        end
    end

    // Input routing and bit decision; inputs are blanked outside reception.
    always_comb begin
        uart_next  = 1'b0;
        valid_next = 1'b0;
        value_next = 1'b0;
        coll_next  = 1'b0;
        amp_hi     = halfbits_i.amp_first;
        amp_lo     = halfbits_i.amp_second;
        if (halfbits_i.amp_second > halfbits_i.amp_first) begin
            amp_hi = halfbits_i.amp_second;
            amp_lo = halfbits_i.amp_first;
        end
        if (state_reg == rxg_pkg::RXG_ST_RECV) begin
            case (cfg_reg.uart_sel)
                rxg_pkg::RXG_UART_LOW:     uart_next = 1'b0;
                rxg_pkg::RXG_UART_ENV_PIN: uart_next = envelope_input_pin_i;
                rxg_pkg::RXG_UART_ANALOG:  uart_next = analog_mod_i;
                default:                   uart_next = pin_mod_i;
            endcase
            if (halfbits_i.valid && level_of(amp_hi) >= cfg_reg.min_level) begin
                valid_next = 1'b1;
                value_next = (halfbits_i.amp_first >= halfbits_i.amp_second);
                // Weaker half must reach coll_level eighths of the stronger half.
                coll_next  = ({3'b000, amp_lo} << rxg_pkg::COLL_SHIFT) >=
                             ({3'b000, amp_hi} * {8'h00, cfg_reg.coll_level});
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= rxg_pkg::RXG_ST_IDLE;
            cnt_reg   <= 6'h00;
            cfg_reg   <= '0;
            uart_reg  <= 1'b0;
            valid_reg <= 1'b0;
            value_reg <= 1'b0;
            coll_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            cfg_reg   <= cfg_next;
            uart_reg  <= uart_next;
            valid_reg <= valid_next;
            value_reg <= value_next;
            coll_reg  <= coll_next;
        end
    end

    logic rx_en_reg;
    logic busy_reg;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_en_reg <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            rx_en_reg <= (state_next == rxg_pkg::RXG_ST_RECV);
            busy_reg  <= (state_next == rxg_pkg::RXG_ST_GUARD) || (state_next == rxg_pkg::RXG_ST_ARMED);
        end
    end

    assign uart_in_o    = uart_reg;
    assign rx_enable_o  = rx_en_reg;
    assign guard_busy_o = busy_reg;
    assign bit_valid_o  = valid_reg;
    assign bit_value_o  = value_reg;
    assign bit_coll_o   = coll_reg;
endmodule

// ===== test/rxg_far.sv
// Far side card model driving the receive pins and half bit amplitudes.
module rxg_far (
    // Clock
    input  wire logic                   clk_i,
    // Bench control
    input  wire logic                   in_frame_i,
    input  wire logic [2:0]             lvl_i,
    input  wire logic                   send_i,
    input  wire logic [15:0]            amp_i,
    // Line side
    output logic                        envelope_input_pin_o,
    output logic                        pin_mod_o,
    output logic                        analog_mod_o,
    output rxg_pkg::rxg_halfbits_t      halfbits_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tgl = 1'b0;
    // Outside a frame the lines toggle, so a stale level can never pass as a match.
    always @(posedge clk_i) tgl <= !tgl;
    assign {envelope_input_pin_o, pin_mod_o, analog_mod_o} = in_frame_i ? lvl_i : {3{tgl}};
    assign halfbits_o = send_i ? {1'b1, amp_i} : {1'b0, {8{tgl}}, {8{!tgl}}};
endmodule

// ===== test/rxg_props.sv
// Checker of the receive guard block port behaviour.
module rxg_props (
    // Clock and reset
    input wire logic                   clk_i,
    input wire logic                   sys_rst_i,
    // Register port
    input wire logic [7:0]             addr_i,
    input wire logic                   rd_i,
    input wire logic [7:0]             rdata_o,
    // Sequencer events
    input wire logic                   cmd_start_i,
    input wire logic                   cmd_recv_only_i,
    input wire logic                   last_mod_pulse_i,
    input wire logic                   ext_field_on_i,
    input wire logic                   bit_clk_i,
    input wire logic                   frame_end_i,
    // Receive side
    input wire rxg_pkg::rxg_halfbits_t halfbits_i,
    input wire logic                   uart_in_o,
    input wire logic                   rx_enable_o,
    input wire logic                   bit_valid_o,
    input wire logic                   guard_busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_arm;
        cmd_start_i && !cmd_recv_only_i;
    endsequence
    // A waiting cycle has no event that could legally end the guard.
    sequence s_wait;
        guard_busy_o && !bit_clk_i && !last_mod_pulse_i && !ext_field_on_i && !cmd_start_i;
    endsequence
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside its answer cycle");
    a_thr_rsvd: assert property ($past(rd_i) && $past(addr_i) == 8'h18 |-> !rdata_o[3])
        else $error("reserved threshold bit reads one");
    a_recv_only: assert property (cmd_start_i && cmd_recv_only_i |=> rx_enable_o && !guard_busy_o)
        else $error("receive only command waited");
    a_guard_arm: assert property (s_arm |=> guard_busy_o && !rx_enable_o)
        else $error("guard not armed");
    a_guard_hold: assert property (s_wait |=> !rx_enable_o)
        else $error("receiver enabled during guard");
    a_rx_rise: assert property ($rose(rx_enable_o) |-> $past(bit_clk_i || last_mod_pulse_i || ext_field_on_i || cmd_start_i))
        else $error("receiver enabled without cause");
    a_bits_gated: assert property (bit_valid_o |-> $past(rx_enable_o && halfbits_i.valid))
        else $error("bit output without half bits");
    a_uart_gated: assert property (!rx_enable_o && !$past(rx_enable_o) |-> !uart_in_o)
        else $error("uart input outside reception");
    a_frame_end: assert property (rx_enable_o && frame_end_i && !cmd_start_i |=> !rx_enable_o)
        else $error("reception kept after frame end");
endmodule

bind rxg_top rxg_props u_props (.clk_i, .sys_rst_i, .addr_i, .rd_i, .rdata_o, .cmd_start_i, .cmd_recv_only_i,
    .last_mod_pulse_i, .ext_field_on_i, .bit_clk_i, .frame_end_i, .halfbits_i, .uart_in_o, .rx_enable_o,
    .bit_valid_o, .guard_busy_o);

// ===== test/tb_rxg_top.sv
// Self-checking bench of the receive guard block.
module tb_rxg_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic                   ro = 1'b0, amode = 1'b0, send = 1'b0;
    logic [7:0]             addr_i = 8'h00, wdata_i = 8'h00, rdata_o, v, thr;
    logic [4:0]             ev = 5'h00;
    logic [2:0]             lvl = 3'h0, e;
    logic [15:0]            amp = 16'h0000, a;
    logic [5:0]             g;
    logic                   env, pmod, amod, uart, rxen, bval, bvalue, bcoll, busy;
    rxg_pkg::rxg_halfbits_t hb;
    int                     n_errors = 0, total_checks = 0;

    rxg_top DUT (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cmd_start_i(ev[0]),
        .cmd_recv_only_i(ro), .active_mode_i(amode), .last_mod_pulse_i(ev[1]), .ext_field_on_i(ev[2]),
        .bit_clk_i(ev[3]), .frame_end_i(ev[4]), .envelope_input_pin_i(env), .pin_mod_i(pmod), .analog_mod_i(amod),
        .halfbits_i(hb), .uart_in_o(uart), .rx_enable_o(rxen), .bit_valid_o(bval), .bit_value_o(bvalue),
        .bit_coll_o(bcoll), .guard_busy_o(busy));
    rxg_far FAR (.clk_i, .in_frame_i(rxen), .lvl_i(lvl), .send_i(send), .amp_i(amp), .envelope_input_pin_o(env),
        .pin_mod_o(pmod), .analog_mod_o(amod), .halfbits_o(hb));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic f_uart(logic [1:0] c, logic [2:0] l);
        return c == 2'h0 ? 1'b0 : c == 2'h1 ? l[2] : c == 2'h2 ? l[0] : l[1];
    endfunction

    function automatic logic [2:0] f_dec(logic [7:0] x, logic [7:0] y, logic [7:0] t);
        logic [7:0] hi;
        logic [7:0] lo;
        hi = x >= y ? x : y;
        lo = x >= y ? y : x;
        return {hi[7:4] >= t[7:4], x >= y, 12'(lo) * 8 >= 12'(hi) * t[2:0]};
    endfunction

    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(logic [7:0] ad, logic [7:0] d);
        @(posedge clk_i);
        addr_i <= ad;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rc(logic [7:0] ad, logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= ad;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask

    task automatic pulse(int k);
        @(posedge clk_i);
        ev <= 5'h01 << k;
        @(posedge clk_i);
        ev <= 5'h00;
        #1;
    endtask

    task automatic dec(logic [15:0] x);
        @(posedge clk_i);
        amp <= x;
        send <= 1'b1;
        @(posedge clk_i);
        send <= 1'b0;
        #1 e = f_dec(x[15:8], x[7:0], thr);
        chk(bval, e[2]);
        if (e[2]) chk({bvalue, bcoll}, e[1:0]);
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        n_errors++;
        final_report();
    end

    initial begin
        void'($urandom(66561));
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rc(8'h17, 8'h84);
        rc(8'h18, 8'h84);
        rc(8'h20, 8'h00);
        wr(8'h18, 8'hFF);
        rc(8'h18, 8'hF7);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            g = (k == 3) ? 6'h3F : 6'(k);
            thr = 8'($urandom) & 8'hF7;
            // Code 11 is set only as the longest guard case.
            wr(8'h17, {2'(k), g});
            wr(8'h18, thr);
            rc(8'h17, {2'(k), g});
            amode <= k[0];
            pulse(0);
            chk(busy, 1'b1);
            pulse(k[0] ? 1 : 2);
            chk({rxen, uart}, 2'b00);
            pulse(k[0] ? 2 : 1);
            for (int i = 0; i < g; i++) begin
                chk(rxen, 1'b0);
                pulse(3);
            end
            chk({rxen, busy}, 2'b10);
            @(posedge clk_i);
            lvl <= 3'($urandom);
            repeat (2) @(posedge clk_i);
            #1 chk(uart, f_uart(2'(k), lvl));
            a = 16'($urandom);
            dec(a);
            wr(8'h18, ~thr);
            dec({a[15:8], a[15:8]});
            pulse(4);
            // The routed input register trails the enable by one cycle, so it is checked a cycle later.
            chk(rxen, 1'b0);
            @(posedge clk_i);
            #1 chk(uart, 1'b0);
            $display("test guard %0d done", k);
        end
        ro <= 1'b1;
        pulse(0);
        chk({rxen, busy}, 2'b10);
        ro <= 1'b0;
        pulse(4);
        $display("test receive only done");
        final_report();
    end
endmodule
